// ===== aacr_top.v
// APB register bank for the two-channel ADC analog front end controls
//
// Summary of operation
// - Bit 6 of channel enable register: channel 2 init (0) or work (1), reset 0.
// - Bit 5 of channel enable register enables channel 2 converter, reset disabled.
// - Bit 4 of channel enable register enables channel 2 clock, reset 0.
// - Bit 2 of channel enable register: channel 1 init (0) or work (1), reset 0.
// - Bit 1 of channel enable register enables channel 1 converter, reset disabled.
// - Bit 0 enables channel 1 clock; bits 31:7 and 3 read zero.
// - Bit 0 at 0x358 enables the shared current source, reset 0.
// - Bits 7:6 select channel 2 microphone input, reset 01, upper bit kept 0.
// - Bits 5:4 select channel 1 microphone input, reset 01, upper bit kept 0.
// - Bit 3 in copies +0x40 and +0x80 enable bias outputs one and two.
// - Bits 2:0 of base copy select bias level 0.50 to 0.85 supply.
// - Bit 4 at 0x360 enables bias current source; bits 3:0 read zero.
`timescale 1ns/1ps
`include "aacr_regs.vh"

module aacr_top #(
	parameter ADDR_W = 12
) (
	input  wire              pclk,
	input  wire              presetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	input  wire [3:0]        pstrb,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	output reg               ch1_clock_enable,
	output reg               ch1_converter_enable,
	output reg               ch1_converter_init,
	output reg               ch2_clock_enable,
	output reg               ch2_converter_enable,
	output reg               ch2_converter_init,
	output reg               adc_current_enable,
	output reg  [1:0]        ch1_input_select,
	output reg  [1:0]        ch2_input_select,
	output reg               mic_bias_output_one,
	output reg               mic_bias_output_two,
	output reg  [2:0]        mic_bias_level_select,
	output reg               mic_bias_current_enable
);

////////////////////////////////////////////////////////////////////////////////
// Helper functions

	// Match a full byte address against a register offset
	function hit;
		input [ADDR_W-1:0] addr;
		input [11:0]       off;
		begin
			hit = (addr == off[ADDR_W-1:0]);
		end
	endfunction

	// One-bit field: take the new value on its strobe, else hold
	function upd1;
		input load;
		input cur;
		input nxt;
		begin
			upd1 = load ? nxt : cur;
		end
	endfunction

	// Two-bit field: take the new value on its strobe, else hold
	function [1:0] upd2;
		input       load;
		input [1:0] cur;
		input [1:0] nxt;
		begin
			upd2 = load ? nxt : cur;
		end
	endfunction

	// Three-bit field: take the new value on its strobe, else hold
	function [2:0] upd3;
		input       load;
		input [2:0] cur;
		input [2:0] nxt;
		begin
			upd3 = load ? nxt : cur;
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
// Address decode and transfer phases

	// One hit per register word, copies at their own addresses
	wire              h_ch    = hit(paddr, `AACR_OFF_CH_EN);
	wire              h_cur   = hit(paddr, `AACR_OFF_CUR_EN);
	wire              h_in0   = hit(paddr, `AACR_OFF_IN_BIAS);
	wire              h_in1   = hit(paddr, `AACR_OFF_IN_BIAS + `AACR_COPY1_OFS);
	wire              h_in2   = hit(paddr, `AACR_OFF_IN_BIAS + `AACR_COPY2_OFS);
	wire              h_bc    = hit(paddr, `AACR_OFF_BIAS_CUR);
	wire              mapped  = h_ch | h_cur | h_in0 | h_in1 | h_in2 | h_bc;

	// Setup cycle: select high, enable still low
	wire              acc_set = psel & ~penable;
	// Access cycle: ready is up, its closing edge completes the transfer
	wire              acc_end = psel & penable & pready;
	// Only byte lane 0 holds fields, so its strobe gates every write
	wire              wr_go   = acc_end & pwrite & mapped & pstrb[0];
	// Read data is captured at the end of setup and stands through access
	wire              rd_cap  = acc_set & ~pwrite;

	// Per-register write strobes
	wire              w_ch    = wr_go & h_ch;
	wire              w_cur   = wr_go & h_cur;
	wire              w_in0   = wr_go & h_in0;
	wire              w_in1   = wr_go & h_in1;
	wire              w_in2   = wr_go & h_in2;
	wire              w_bc    = wr_go & h_bc;

////////////////////////////////////////////////////////////////////////////////
// Next values of the control fields

	// Next value of every field
	reg               ch2_init_d;
	reg               ch2_en_d;
	reg               ch2_clk_d;
	reg               ch1_init_d;
	reg               ch1_en_d;
	reg               ch1_clk_d;
	reg               cur_en_d;
	reg  [1:0]        ch2_sel_d;
	reg  [1:0]        ch1_sel_d;
	reg  [2:0]        level_d;
	reg               buf1_d;
	reg               buf2_d;
	reg               bcur_d;

	// Write data slices of the base input and bias word
	wire [1:0]        wd_ch2_sel = pwdata[`AACR_CH2_SEL_HI:`AACR_CH2_SEL_LO];
	wire [1:0]        wd_ch1_sel = pwdata[`AACR_CH1_SEL_HI:`AACR_CH1_SEL_LO];
	wire [2:0]        wd_level   = pwdata[`AACR_LEVEL_HI:`AACR_LEVEL_LO];

	// Channel enable register
	always @* begin
		ch2_init_d = upd1(w_ch, ch2_converter_init, pwdata[`AACR_CH2_INIT_BIT]);
		ch2_en_d   = upd1(w_ch, ch2_converter_enable, pwdata[`AACR_CH2_EN_BIT]);
		ch2_clk_d  = upd1(w_ch, ch2_clock_enable, pwdata[`AACR_CH2_CLK_BIT]);
		ch1_init_d = upd1(w_ch, ch1_converter_init, pwdata[`AACR_CH1_INIT_BIT]);
		ch1_en_d   = upd1(w_ch, ch1_converter_enable, pwdata[`AACR_CH1_EN_BIT]);
		ch1_clk_d  = upd1(w_ch, ch1_clock_enable, pwdata[`AACR_CH1_CLK_BIT]);
	end

	// Shared current source of both converters
	always @* begin
		cur_en_d = upd1(w_cur, adc_current_enable, pwdata[`AACR_CUR_EN_BIT]);
	end

	// Base copy; upper select bits stored as written, software keeps them 0
	always @* begin
		ch2_sel_d = upd2(w_in0, ch2_input_select, wd_ch2_sel);
		ch1_sel_d = upd2(w_in0, ch1_input_select, wd_ch1_sel);
		level_d   = upd3(w_in0, mic_bias_level_select, wd_level);
	end

	// Buffer enables live only in the two offset copies
	always @* begin
		buf1_d = upd1(w_in1, mic_bias_output_one, pwdata[`AACR_BUF_EN_BIT]);
		buf2_d = upd1(w_in2, mic_bias_output_two, pwdata[`AACR_BUF_EN_BIT]);
	end

	// Bias current source, base copy only
	always @* begin
		bcur_d = upd1(w_bc, mic_bias_current_enable, pwdata[`AACR_BCUR_EN_BIT]);
	end

////////////////////////////////////////////////////////////////////////////////
// Control field registers

	// Channel enable register, every field clear at reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch2_converter_init   <= `AACR_BIT_RST;
			ch2_converter_enable <= `AACR_BIT_RST;
			ch2_clock_enable     <= `AACR_BIT_RST;
			ch1_converter_init   <= `AACR_BIT_RST;
			ch1_converter_enable <= `AACR_BIT_RST;
			ch1_clock_enable     <= `AACR_BIT_RST;
		end else begin
			ch2_converter_init   <= ch2_init_d;
			ch2_converter_enable <= ch2_en_d;
			ch2_clock_enable     <= ch2_clk_d;
			ch1_converter_init   <= ch1_init_d;
			ch1_converter_enable <= ch1_en_d;
			ch1_clock_enable     <= ch1_clk_d;
		end
	end

	// Shared current source, off at reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			adc_current_enable <= `AACR_BIT_RST;
		else
			adc_current_enable <= cur_en_d;
	end

	// Input selects reset to microphone, bias level to its lowest code
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch2_input_select      <= `AACR_SEL_RST;
			ch1_input_select      <= `AACR_SEL_RST;
			mic_bias_level_select <= `AACR_LEVEL_RST;
		end else begin
			ch2_input_select      <= ch2_sel_d;
			ch1_input_select      <= ch1_sel_d;
			mic_bias_level_select <= level_d;
		end
	end

	// Bias buffer enables, off at reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mic_bias_output_one <= `AACR_BIT_RST;
			mic_bias_output_two <= `AACR_BIT_RST;
		end else begin
			mic_bias_output_one <= buf1_d;
			mic_bias_output_two <= buf2_d;
		end
	end

	// Bias current source, off at reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mic_bias_current_enable <= `AACR_BIT_RST;
		else
			mic_bias_current_enable <= bcur_d;
	end

////////////////////////////////////////////////////////////////////////////////
// Read images, reserved bits zero

	// Per-register read words and the read path
	reg  [31:0]       img_ch;
	reg  [31:0]       img_cur;
	reg  [31:0]       img_in0;
	reg  [31:0]       img_in1;
	reg  [31:0]       img_in2;
	reg  [31:0]       img_bc;
	reg  [31:0]       rd_img;
	reg  [31:0]       prdata_d;

	// Channel enable word; bits 31:7 and 3 stay zero
	always @* begin
		img_ch                     = `AACR_ZERO32;
		img_ch[`AACR_CH2_INIT_BIT] = ch2_converter_init;
		img_ch[`AACR_CH2_EN_BIT]   = ch2_converter_enable;
		img_ch[`AACR_CH2_CLK_BIT]  = ch2_clock_enable;
		img_ch[`AACR_CH1_INIT_BIT] = ch1_converter_init;
		img_ch[`AACR_CH1_EN_BIT]   = ch1_converter_enable;
		img_ch[`AACR_CH1_CLK_BIT]  = ch1_clock_enable;
	end

	// Shared current word
	always @* begin
		img_cur                   = `AACR_ZERO32;
		img_cur[`AACR_CUR_EN_BIT] = adc_current_enable;
	end

	// Base copy of the input and bias word; bit 3 reads zero here
	always @* begin
		img_in0                                    = `AACR_ZERO32;
		img_in0[`AACR_CH2_SEL_HI:`AACR_CH2_SEL_LO] = ch2_input_select;
		img_in0[`AACR_CH1_SEL_HI:`AACR_CH1_SEL_LO] = ch1_input_select;
		img_in0[`AACR_LEVEL_HI:`AACR_LEVEL_LO]     = mic_bias_level_select;
	end

	// Offset copies hold only their buffer enable
	always @* begin
		img_in1                   = `AACR_ZERO32;
		img_in1[`AACR_BUF_EN_BIT] = mic_bias_output_one;
		img_in2                   = `AACR_ZERO32;
		img_in2[`AACR_BUF_EN_BIT] = mic_bias_output_two;
	end

	// Bias current word; bits 3:0 read zero
	always @* begin
		img_bc                    = `AACR_ZERO32;
		img_bc[`AACR_BCUR_EN_BIT] = mic_bias_current_enable;
	end

	// Word of the addressed register; unmapped addresses read zero
	always @* begin
		rd_img = `AACR_ZERO32;
		if (h_ch)
			rd_img = img_ch;
		if (h_cur)
			rd_img = img_cur;
		if (h_in0)
			rd_img = img_in0;
		if (h_in1)
			rd_img = img_in1;
		if (h_in2)
			rd_img = img_in2;
		if (h_bc)
			rd_img = img_bc;
	end

	// Load on read setup, clear when idle, hold otherwise
	always @* begin
		prdata_d = prdata;
		if (rd_cap)
			prdata_d = rd_img;
		else if (!psel)
			prdata_d = `AACR_ZERO32;
	end

////////////////////////////////////////////////////////////////////////////////
// APB response: no wait states, read data registered

	// Ready follows every setup cycle by exactly one clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= `AACR_BIT_RST;
			pslverr <= `AACR_BIT_RST;
			prdata  <= `AACR_ZERO32;
		end else begin
			pready  <= acc_set;
			pslverr <= acc_set & ~mapped;
			prdata  <= prdata_d;
		end
	end

endmodule // aacr_top

// ===== aacr_regs.vh
// Register map, field positions and reset values of the ADC analog control bank
`ifndef AACR_REGS_VH
`define AACR_REGS_VH
`define AACR_OFF_CH_EN     12'h354
`define AACR_OFF_CUR_EN    12'h358
`define AACR_OFF_IN_BIAS   12'h35c
`define AACR_OFF_BIAS_CUR  12'h360
`define AACR_COPY1_OFS     12'h040
`define AACR_COPY2_OFS     12'h080
`define AACR_CH2_INIT_BIT  6
`define AACR_CH2_EN_BIT    5
`define AACR_CH2_CLK_BIT   4
`define AACR_CH1_INIT_BIT  2
`define AACR_CH1_EN_BIT    1
`define AACR_CH1_CLK_BIT   0
`define AACR_CUR_EN_BIT    0
`define AACR_CH2_SEL_HI    7
`define AACR_CH2_SEL_LO    6
`define AACR_CH1_SEL_HI    5
`define AACR_CH1_SEL_LO    4
`define AACR_BUF_EN_BIT    3
`define AACR_LEVEL_HI      2
`define AACR_LEVEL_LO      0
`define AACR_BCUR_EN_BIT   4
`define AACR_SEL_RST       2'h1
`define AACR_LEVEL_RST     3'h0
`define AACR_BIT_RST       1'h0
`define AACR_ZERO32        32'h00000000
`endif

// ===== aacr_top_assertions.sv
// Concurrent checks on the APB side and control outputs of the ADC analog bank
`timescale 1ns/1ps
module aacr_top_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [3:0]  pstrb,
	input wire logic        ch1_clock_enable,
	input wire logic        ch2_converter_init,
	input wire logic        adc_current_enable,
	input wire logic [2:0]  mic_bias_level_select,
	input wire logic        mic_bias_current_enable
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed write with the low byte strobed
	wire wr = pready && pwrite && pstrb[0];
	chk_ready_slot: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
	chk_ch2_init: assert property (wr && paddr == 12'h354 |=>
		ch2_converter_init == $past(pwdata[6])) else $error("init bit wrong");
	chk_ch1_clock: assert property (wr && paddr == 12'h354 |=>
		ch1_clock_enable == $past(pwdata[0])) else $error("clock bit wrong");
	chk_cur_en: assert property (wr && paddr == 12'h358 |=>
		adc_current_enable == $past(pwdata[0])) else $error("current bit wrong");
	chk_bias_level: assert property (wr && paddr == 12'h35c |=>
		mic_bias_level_select == $past(pwdata[2:0])) else $error("level wrong");
	chk_bias_cur: assert property (wr && paddr == 12'h360 |=>
		mic_bias_current_enable == $past(pwdata[4])) else $error("bias current wrong");
	chk_rsvd_zero: assert property (pready && !pwrite && paddr == 12'h354 |->
		prdata[31:7] == 0 && !prdata[3]) else $error("reserved bits set");
	chk_unmapped_err: assert property (pready && paddr == 12'h3fc |->
		pslverr && (pwrite || prdata == 0)) else $error("unmapped access wrong");
endmodule // aacr_top_chk

// ===== aacr_top_test.sv
// Self-checking bench for the ADC analog control register bank
`timescale 1ns/1ps
module aacr_top_test;
	logic        pclk = 0, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed, r, d, s, sh[7];
	logic [3:0]  pstrb;
	logic        ch1_clock_enable, ch1_converter_enable, ch1_converter_init, e;
	logic        ch2_clock_enable, ch2_converter_enable, ch2_converter_init;
	logic        adc_current_enable, mic_bias_output_one, mic_bias_output_two;
	logic        mic_bias_current_enable;
	logic [1:0]  ch1_input_select, ch2_input_select;
	logic [2:0]  mic_bias_level_select;
	logic [11:0] ad[7] = '{12'h354, 12'h358, 12'h35c, 12'h360, 12'h39c, 12'h3dc, 12'h3fc};
	logic [31:0] mk[7] = '{32'h77, 32'h1, 32'hf7, 32'h10, 32'h8, 32'h8, 32'h0};
	integer      errors = 0, n_compared = 0, k;
	aacr_top dut_u (
		.pclk                    (pclk),
		.presetn                 (presetn),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.pstrb                   (pstrb),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.ch1_clock_enable        (ch1_clock_enable),
		.ch1_converter_enable    (ch1_converter_enable),
		.ch1_converter_init      (ch1_converter_init),
		.ch2_clock_enable        (ch2_clock_enable),
		.ch2_converter_enable    (ch2_converter_enable),
		.ch2_converter_init      (ch2_converter_init),
		.adc_current_enable      (adc_current_enable),
		.ch1_input_select        (ch1_input_select),
		.ch2_input_select        (ch2_input_select),
		.mic_bias_output_one     (mic_bias_output_one),
		.mic_bias_output_two     (mic_bias_output_two),
		.mic_bias_level_select   (mic_bias_level_select),
		.mic_bias_current_enable (mic_bias_current_enable)
	);
	always #12.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task report_and_stop;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] sn, xp);
		n_compared++;
		if (sn !== xp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, sn, xp);
		end
	endtask
	// Control outputs expected from the shadow registers
	function [31:0] outs_exp;
		outs_exp = {15'h0, sh[0][6:4], sh[0][2:0], sh[1][0], sh[2][7:4], sh[2][2:0],
			sh[3][4], sh[4][3], sh[5][3]};
	endfunction
	wire [31:0] outs = {15'h0, ch2_converter_init, ch2_converter_enable, ch2_clock_enable,
		ch1_converter_init, ch1_converter_enable, ch1_clock_enable, adc_current_enable,
		ch2_input_select, ch1_input_select, mic_bias_level_select, mic_bias_current_enable,
		mic_bias_output_one, mic_bias_output_two};
	// One APB transfer, bounded wait on pready
	task apb(input w, input [11:0] a, input [31:0] dt, input [3:0] st);
		integer i;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, dt, st};
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (!pready && i < 20);
		if (!pready) begin
			errors++;
			report_and_stop;
		end
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Reset values, then random writes with read-back
	initial begin
		seed = 32'h21787337;
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} <= 0;
		foreach (sh[j]) sh[j] = 0;
		sh[2] = 32'h50;
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk(outs, outs_exp());
		for (k = 0; k < 7; k++) begin
			apb(0, ad[k], 0, 4'h0);
			chk(r, sh[k]);
		end
		repeat (80) begin
			k = $unsigned($random(seed)) % 7;
			d = $random(seed);
			// Software keeps the upper input select bits at zero
			if (k == 2) d[7] = 1'b0;
			if (k == 2) d[5] = 1'b0;
			s = $random(seed);
			apb(1, ad[k], d, s[3:0]);
			if (s[0]) sh[k] = d & mk[k];
			chk({31'h0, e}, {31'h0, k == 6});
			apb(0, ad[k], 0, 4'h0);
			chk(r, sh[k]);
			chk(outs, outs_exp());
		end
		// Mid-run reset returns every field to its reset value
		@(posedge pclk);
		presetn <= 0;
		@(posedge pclk);
		foreach (sh[j]) sh[j] = 0;
		sh[2] = 32'h50;
		chk(outs, outs_exp());
		presetn <= 1;
		for (k = 0; k < 7; k++) begin
			apb(0, ad[k], 0, 4'h0);
			chk(r, sh[k]);
		end
		report_and_stop;
	end
endmodule // aacr_top_test
bind aacr_top aacr_top_chk chk_u (
	.pclk                    (pclk),
	.presetn                 (presetn),
	.psel                    (psel),
	.penable                 (penable),
	.pwrite                  (pwrite),
	.pready                  (pready),
	.pslverr                 (pslverr),
	.paddr                   (paddr),
	.pwdata                  (pwdata),
	.prdata                  (prdata),
	.pstrb                   (pstrb),
	.ch1_clock_enable        (ch1_clock_enable),
	.ch2_converter_init      (ch2_converter_init),
	.adc_current_enable      (adc_current_enable),
	.mic_bias_level_select   (mic_bias_level_select),
	.mic_bias_current_enable (mic_bias_current_enable)
);
